// *** verilog/cap_pkg.sv ***
// Summary of operation
// - bit 7 connects external ground switch pin
// - ground switch with mode bit 6 selects resistor
// - accumulator mode 00 disables and clears total
// - mode 01 adds signed results, clamps at zero
// - mode 10 adds signed results, goes below zero
// - 32-bit total wraps; mode 11 is undefined
// - comparator 00 off; 01 interrupts when at or above threshold
// - mode 10 counts hits, below-threshold clears count
// - mode 11 counts hits, below-threshold decrements count
// - bit 2 enables coarse overrange status flag
// - overrange must persist beyond 125 us
// - bit 0 gives ready interrupt only at result count limit
// - other converter keeps latest result only
// - result count returns to zero at limit
// - 8-bit threshold count increments on each hit up to 255
// - threshold status sets when count equals limit
package cap_pkg;

	// configuration register reset value and field positions
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int ANALOG_GROUND_SWITCH_PIN_BIT = 7;
	localparam int ACC_MODE_LSB = 5;
	localparam int CMP_MODE_LSB = 3;
	localparam int OVR_EN_BIT = 2;
	localparam int RSVD_BIT = 1;
	localparam int RCNT_EN_BIT = 0;

	// result counter, threshold counter and accumulator reset values
	localparam logic [15:0] RCV_RESET = 16'h0000;
	localparam logic [7:0] THV_RESET = 8'h00;
	localparam logic [31:0] ACC_RESET = 32'h0000_0000;

	// overrange persistence time and its cycle count at 20 MHz
	localparam int OVR_TIME_NS = 125000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int OVR_CYCLES = OVR_TIME_NS / CLK_PERIOD_NS;

	// accumulator modes
	typedef enum logic [1:0] {
		CAP_ACC_OFF = 2'b00,
		CAP_ACC_CLAMP = 2'b01,
		CAP_ACC_SIGNED = 2'b10,
		CAP_ACC_UNDEF = 2'b11
	} cap_acc_mode_e;

	// comparator modes
	typedef enum logic [1:0] {
		CAP_CMP_OFF = 2'b00,
		CAP_CMP_IMMED = 2'b01,
		CAP_CMP_CNT_CLR = 2'b10,
		CAP_CMP_CNT_DEC = 2'b11
	} cap_cmp_mode_e;

	// configuration register layout, msb first
	typedef struct packed {
		logic analog_ground_switch_pin;
		cap_acc_mode_e acc_mode;
		cap_cmp_mode_e cmp_mode;
		logic ovr_en;
		logic rsvd;
		logic rcnt_en;
	} cap_cfg_s;

	// one conversion result with its strobe
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} cap_result_s;

endpackage

// *** verilog/cap_ovr_filter.sv ***
`timescale 1ns/10ps
module cap_ovr_filter #(
	parameter int CYCLES = cap_pkg::OVR_CYCLES
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// control and coarse comparator level
	input wire logic enable_i,
	input wire logic raw_i,
	// one-cycle pulse when the overrange has lasted long enough
	output logic hit_o
);

	// counter must hold one beyond the limit
	if (CYCLES < 1 || CYCLES > 4094) begin : g_bad_cycles
		$error("cap_ovr_filter: CYCLES out of range");
	end

	logic s1_ff, s2_ff, s3_ff; // three-stage synchroniser
	logic lvl_ff, nxt_lvl; // accepted level
	logic [11:0] cnt_ff, nxt_cnt; // time spent out of range
	logic hit_ff, nxt_hit;

	// next state: level accepted only when stages two and three agree
	always_comb begin
		nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
		nxt_cnt = cnt_ff;
		nxt_hit = 1'b0;
		if (!enable_i || !lvl_ff) begin
			// a return into range lasting two cycles or more restarts the timing
			nxt_cnt = 12'h000;
		end else if (cnt_ff <= 12'(CYCLES)) begin
			nxt_cnt = cnt_ff + 12'h001;
			// strictly longer than the limit before flagging
			nxt_hit = (cnt_ff == 12'(CYCLES));
		end
	end

	// registers only
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			lvl_ff <= 1'b0;
			cnt_ff <= 12'h000;
			hit_ff <= 1'b0;
		end else begin
			s1_ff <= raw_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
			cnt_ff <= nxt_cnt;
			hit_ff <= nxt_hit;
		end
	end

	assign hit_o = hit_ff;

	property p_ovr_persist;
		@(posedge mclk_i) disable iff (!resetn_i)
		// level and enable may drop on the very edge that raises the
		// pulse, so judge them as they stood when the pulse was decided
		hit_o |-> $past(lvl_ff) && $past(enable_i)
			&& cnt_ff == 12'(CYCLES + 1);
	endproperty
	a_ovr_persist: assert property (p_ovr_persist)
		else $error("overrange flagged before persistence time");

endmodule

// *** verilog/cap_top.sv ***
`timescale 1ns/10ps
module cap_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// configuration register port
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	// settings held in neighbouring registers
	input wire logic mode_bit6_i,
	input wire logic mode_write_i,
	input wire logic [15:0] threshold_i,
	input wire logic [7:0] threshold_count_limit_i,
	input wire logic [15:0] result_count_limit_i,
	// current results and coarse overrange level
	input wire cap_pkg::cap_result_s cur_i,
	input wire logic overrange_raw_i,
	// voltage or temperature results
	input wire cap_pkg::cap_result_s vt_i,
	// status flag clears from software
	input wire logic cmp_flag_clr_i,
	input wire logic ovr_flag_clr_i,
	// ground switch pin controls
	output logic analog_ground_switch_pin_connect_o,
	output logic analog_ground_switch_pin_resistor_o,
	// accumulator, counters and latest other-channel result
	output logic [31:0] accumulator_o,
	output logic [7:0] threshold_count_value_o,
	output logic [15:0] result_count_value_o,
	output logic [15:0] vt_latest_o,
	// status and interrupt
	output logic cmp_flag_o,
	output logic ovr_flag_o,
	output logic irq_o
);

	// magnitude of a two's complement result, used by both paths
	function automatic logic [15:0] mag16(input logic [15:0] v);
		mag16 = v[15] ? (16'h0000 - v) : v;
	endfunction

	cap_pkg::cap_cfg_s cfg_ff, nxt_cfg; // configuration register
	logic gnd_res_ff, nxt_gnd_res; // resistor path select
	logic [31:0] acc_ff, nxt_acc; // current accumulator
	logic [7:0] thv_ff, nxt_thv; // threshold counter
	logic [15:0] rcv_ff, nxt_rcv; // result counter
	logic [15:0] vt_ff, nxt_vt; // latest other-channel result
	logic cmpf_ff, nxt_cmpf; // threshold status
	logic ovrf_ff, nxt_ovrf; // overrange status
	logic irq_ff, nxt_irq; // interrupt pulse
	logic ovr_hit; // persistence met
	logic [15:0] mag; // |current result|
	logic over_th; // magnitude at or above threshold
	logic [31:0] sext; // result widened to accumulator
	logic rc_hit; // result count reached limit
	logic cnt_mode; // comparator counting modes

	// coarse overrange timing runs in its own small block
	cap_ovr_filter #(
		.CYCLES(cap_pkg::OVR_CYCLES)
	) u_ovr (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.enable_i(cfg_ff.ovr_en),
		.raw_i(overrange_raw_i),
		.hit_o(ovr_hit)
	);

	// decode shared by several paths
	always_comb begin
		mag = mag16(cur_i.data);
		over_th = (mag >= threshold_i);
		sext = {{16{cur_i.data[15]}}, cur_i.data};
		rc_hit = ((rcv_ff + 16'h0001) == result_count_limit_i);
		cnt_mode = cfg_ff.cmp_mode[1];
	end

	// configuration register and ground switch
	always_comb begin
		nxt_cfg = cfg_ff;
		if (cfg_wr_i) begin
			nxt_cfg = cap_pkg::cap_cfg_s'(cfg_wdata_i);
			// reserved bit is not stored and reads zero
			nxt_cfg.rsvd = 1'b0;
		end
		// resistor path needs both the enable and mode bit 6
		nxt_gnd_res = cfg_ff.analog_ground_switch_pin & mode_bit6_i;
	end

	// accumulator; no top saturation so a long run wraps
	always_comb begin
		nxt_acc = acc_ff;
		case (cfg_ff.acc_mode)
			cap_pkg::CAP_ACC_OFF: begin
				// held at zero while off
				nxt_acc = 32'h0000_0000;
			end
			cap_pkg::CAP_ACC_CLAMP: begin
				if (cur_i.valid) begin
					// negative result floors the total at zero
					if (cur_i.data[15] && acc_ff < {16'h0000, mag}) begin
						nxt_acc = 32'h0000_0000;
					end else begin
						nxt_acc = acc_ff + sext;
					end
				end
			end
			cap_pkg::CAP_ACC_SIGNED: begin
				// adding the signed value subtracts |I| below zero
				if (cur_i.valid) begin
					nxt_acc = acc_ff + sext;
				end
			end
			default: begin
				// undefined code: total simply holds
				nxt_acc = acc_ff;
			end
		endcase
	end

	// threshold counter and its status flag
	always_comb begin
		nxt_thv = thv_ff;
		if (cur_i.valid) begin
			case (cfg_ff.cmp_mode)
				cap_pkg::CAP_CMP_CNT_CLR: begin
					if (over_th) begin
						// saturate rather than wrap back to zero
						nxt_thv = (thv_ff == 8'hff) ? thv_ff : thv_ff + 8'h01;
					end else begin
						nxt_thv = 8'h00;
					end
				end
				cap_pkg::CAP_CMP_CNT_DEC: begin
					if (over_th) begin
						nxt_thv = (thv_ff == 8'hff) ? thv_ff : thv_ff + 8'h01;
					end else if (thv_ff != 8'h00) begin
						nxt_thv = thv_ff - 8'h01;
					end
				end
				default: begin
					nxt_thv = thv_ff;
				end
			endcase
		end
		// set beats clear, so an event in the clearing cycle survives
		nxt_cmpf = cmpf_ff & ~cmp_flag_clr_i;
		if (cnt_mode && thv_ff == threshold_count_limit_i) begin
			nxt_cmpf = 1'b1;
		end
		if (cur_i.valid && cfg_ff.cmp_mode == cap_pkg::CAP_CMP_IMMED
			&& over_th) begin
			nxt_cmpf = 1'b1;
		end
	end

	// result counter, overrange flag, other channel, interrupt
	always_comb begin
		nxt_rcv = rcv_ff;
		if (mode_write_i) begin
			// reconfiguring the converter restarts the count
			nxt_rcv = 16'h0000;
		end else if (cur_i.valid && cfg_ff.rcnt_en) begin
			nxt_rcv = rc_hit ? 16'h0000 : rcv_ff + 16'h0001;
		end
		nxt_ovrf = (ovrf_ff & ~ovr_flag_clr_i) | ovr_hit;
		// only the newest result is kept
		nxt_vt = vt_i.valid ? vt_i.data : vt_ff;
		nxt_irq = 1'b0;
		if (cur_i.valid) begin
			// ready interrupt masked until the limit
			nxt_irq = cfg_ff.rcnt_en ? (rc_hit && !mode_write_i) : 1'b1;
			if (cfg_ff.cmp_mode == cap_pkg::CAP_CMP_IMMED && over_th) begin
				nxt_irq = 1'b1;
			end
			if (cnt_mode && over_th
				&& nxt_thv == threshold_count_limit_i) begin
				nxt_irq = 1'b1;
			end
		end
	end

	// all state registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_ff <= cap_pkg::cap_cfg_s'(cap_pkg::CFG_RESET);
			gnd_res_ff <= 1'b0;
			acc_ff <= cap_pkg::ACC_RESET;
			thv_ff <= cap_pkg::THV_RESET;
			rcv_ff <= cap_pkg::RCV_RESET;
			vt_ff <= 16'h0000;
			cmpf_ff <= 1'b0;
			ovrf_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			gnd_res_ff <= nxt_gnd_res;
			acc_ff <= nxt_acc;
			thv_ff <= nxt_thv;
			rcv_ff <= nxt_rcv;
			vt_ff <= nxt_vt;
			cmpf_ff <= nxt_cmpf;
			ovrf_ff <= nxt_ovrf;
			irq_ff <= nxt_irq;
		end
	end

	// outputs straight from flip-flops
	assign cfg_rdata_o = cfg_ff;
	assign analog_ground_switch_pin_connect_o = cfg_ff.analog_ground_switch_pin;
	assign analog_ground_switch_pin_resistor_o = gnd_res_ff;
	assign accumulator_o = acc_ff;
	assign threshold_count_value_o = thv_ff;
	assign result_count_value_o = rcv_ff;
	assign vt_latest_o = vt_ff;
	assign cmp_flag_o = cmpf_ff;
	assign ovr_flag_o = ovrf_ff;
	assign irq_o = irq_ff;

	property p_gnd_conn;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_wr_i |=> analog_ground_switch_pin_connect_o == $past(cfg_wdata_i[7]);
	endproperty
	a_gnd_conn: assert property (p_gnd_conn)
		else $error("ground switch does not follow bit 7");

	property p_gnd_res;
		@(posedge mclk_i) disable iff (!resetn_i)
		analog_ground_switch_pin_connect_o && mode_bit6_i |=> analog_ground_switch_pin_resistor_o;
	endproperty
	a_gnd_res: assert property (p_gnd_res)
		else $error("resistor path not selected");

	property p_acc_off;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.acc_mode == cap_pkg::CAP_ACC_OFF |=> accumulator_o == 32'h0;
	endproperty
	a_acc_off: assert property (p_acc_off)
		else $error("accumulator not cleared while off");

	property p_acc_clamp;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.acc_mode == cap_pkg::CAP_ACC_CLAMP && cur_i.valid
			&& cur_i.data[15] && acc_ff < {16'h0000, mag}
			|=> accumulator_o == 32'h0;
	endproperty
	a_acc_clamp: assert property (p_acc_clamp)
		else $error("accumulator went below zero in clamp mode");

	property p_acc_signed;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.acc_mode == cap_pkg::CAP_ACC_SIGNED && cur_i.valid
			|=> accumulator_o == $past(acc_ff) + $past(sext);
	endproperty
	a_acc_signed: assert property (p_acc_signed)
		else $error("signed accumulation wrong");

	property p_cmp_immed;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.cmp_mode == cap_pkg::CAP_CMP_IMMED && cur_i.valid && over_th
			|=> irq_o && cmp_flag_o;
	endproperty
	a_cmp_immed: assert property (p_cmp_immed)
		else $error("no interrupt on threshold hit");

	property p_cnt_clr;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.cmp_mode == cap_pkg::CAP_CMP_CNT_CLR && cur_i.valid
			&& !over_th |=> threshold_count_value_o == 8'h00;
	endproperty
	a_cnt_clr: assert property (p_cnt_clr)
		else $error("threshold count not cleared");

	property p_cnt_dec;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.cmp_mode == cap_pkg::CAP_CMP_CNT_DEC && cur_i.valid
			&& !over_th && thv_ff != 8'h00
			|=> threshold_count_value_o == $past(thv_ff) - 8'h01;
	endproperty
	a_cnt_dec: assert property (p_cnt_dec)
		else $error("threshold count not decremented");

	property p_rc_mask;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.rcnt_en && cfg_ff.cmp_mode == cap_pkg::CAP_CMP_OFF
			&& cur_i.valid && !rc_hit |=> !irq_o;
	endproperty
	a_rc_mask: assert property (p_rc_mask)
		else $error("interrupt before result count limit");

	property p_rc_wrap;
		@(posedge mclk_i) disable iff (!resetn_i)
		cfg_ff.rcnt_en && cur_i.valid && rc_hit
			|=> result_count_value_o == 16'h0000;
	endproperty
	a_rc_wrap: assert property (p_rc_wrap)
		else $error("result count did not restart");

	property p_thv_flag;
		@(posedge mclk_i) disable iff (!resetn_i)
		cnt_mode && thv_ff == threshold_count_limit_i |=> cmp_flag_o;
	endproperty
	a_thv_flag: assert property (p_thv_flag)
		else $error("threshold status not set at limit");

	property p_ovr_flag;
		@(posedge mclk_i) disable iff (!resetn_i)
		ovr_hit |=> ovr_flag_o;
	endproperty
	a_ovr_flag: assert property (p_ovr_flag)
		else $error("overrange flag not set");

endmodule

// *** bench/cap_src.sv ***
`timescale 1ns/10ps
module cap_src (
	// clock
	input wire logic mclk_i,
	// send request from the bench
	input wire logic send_i,
	input wire logic [15:0] data_i,
	// conversion result toward the block
	output cap_pkg::cap_result_s res_o
);
	// one-cycle strobe per result; idle data flips so a stale value
	// never looks like a held result
	always_ff @(posedge mclk_i) begin
		res_o.valid <= send_i;
		res_o.data <= send_i ? data_i : ~res_o.data;
	end
endmodule

// *** bench/cap_top_tb_top.sv ***
`timescale 1ns/10ps
module cap_top_tb_top;
	// expected outputs after one current result
	typedef struct packed {
		logic [31:0] acc;
		logic [7:0] thv;
		logic [15:0] rcv;
		logic irq;
	} cap_note_s;
	// design stimulus
	logic mclk_i, resetn_i, cfg_wr, mode6, mode_wr, send, raw;
	logic cmp_clr, ovr_clr, v_d;
	logic [7:0] cfg_wd, tcl, cfg_m, thv_m;
	logic [15:0] th, rcl, sdata, rcv_m;
	logic [31:0] acc_m;
	cap_pkg::cap_result_s cur, vt;
	// design observation
	logic [7:0] cfg_rd, thv;
	logic [15:0] rcv, vt_l;
	logic [31:0] acc;
	logic conn, resis, cmp_f, ovr_f, irq;
	// bookkeeping
	cap_note_s nq[$];
	cap_note_s nt;
	integer failures, n_checks, i;
	integer seed = 32'h2f577098;

	cap_src src_u (.mclk_i(mclk_i), .send_i(send), .data_i(sdata),
		.res_o(cur));
	cap_top dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_wr_i(cfg_wr),
		.cfg_wdata_i(cfg_wd), .cfg_rdata_o(cfg_rd), .mode_bit6_i(mode6),
		.mode_write_i(mode_wr), .threshold_i(th),
		.threshold_count_limit_i(tcl), .result_count_limit_i(rcl),
		.cur_i(cur), .overrange_raw_i(raw), .vt_i(vt),
		.cmp_flag_clr_i(cmp_clr), .ovr_flag_clr_i(ovr_clr),
		.analog_ground_switch_pin_connect_o(conn), .analog_ground_switch_pin_resistor_o(resis),
		.accumulator_o(acc), .threshold_count_value_o(thv),
		.result_count_value_o(rcv), .vt_latest_o(vt_l), .cmp_flag_o(cmp_f),
		.ovr_flag_o(ovr_f), .irq_o(irq));

	// free-running 20 mhz clock
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	// one comparison, counted; four-state equality so x only matches x
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (e !== g) begin
			failures++;
			$display("mismatch %0s exp %h got %h", n, e, g);
		end
	endtask

	task tdone(input string n);
		$display("test %0s done", n);
	endtask

	// verdict and end of run, shared with the watchdog
	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// config write; bit 1 is always left clear by software
	task wcfg(input logic [7:0] v);
		// stimulus only moves just after a rising edge
		if (mclk_i === 1'b0) @(posedge mclk_i);
		cfg_wr <= 1'b1;
		cfg_wd <= v;
		cfg_m = v;
		if (v[6:5] == 2'b00) acc_m = 32'h0;
		@(posedge mclk_i);
		cfg_wr <= 1'b0;
		@(posedge mclk_i);
	endtask

	// send one result and note what the outputs must become
	task res(input logic [15:0] d);
		logic [15:0] m;
		logic hit, ri, ci;
		// called after a falling-edge look: wait for the rising edge
		if (mclk_i === 1'b0) @(posedge mclk_i);
		m = d[15] ? (~d + 16'h1) : d;
		hit = m >= th;
		case (cfg_m[6:5])
			2'b00: acc_m = 32'h0;
			2'b01: acc_m = !d[15] ? acc_m + m :
				(acc_m < m ? 32'h0 : acc_m - m);
			2'b10: acc_m = acc_m + {{16{d[15]}}, d};
			default: ; // undefined mode holds the total
		endcase
		ci = cfg_m[3] && hit;
		if (cfg_m[4]) begin
			if (hit) thv_m = thv_m == 8'hff ? thv_m : thv_m + 8'h1;
			else if (cfg_m[3]) thv_m = thv_m == 8'h0 ? 8'h0 : thv_m - 8'h1;
			else thv_m = 8'h0;
			ci = hit && thv_m == tcl;
		end
		ri = 1'b1;
		if (cfg_m[0]) begin
			ri = rcv_m + 16'h1 == rcl;
			rcv_m = ri ? 16'h0 : rcv_m + 16'h1;
		end
		nq.push_back('{acc_m, thv_m, rcv_m, ri | ci});
		send <= 1'b1;
		sdata <= d;
		@(posedge mclk_i);
	endtask

	task rest(input int n);
		send <= 1'b0;
		repeat (n) @(posedge mclk_i);
	endtask

	task pulse_clr(input int which);
		if (mclk_i === 1'b0) @(posedge mclk_i);
		if (which == 0) cmp_clr <= 1'b1;
		else ovr_clr <= 1'b1;
		@(posedge mclk_i);
		cmp_clr <= 1'b0;
		ovr_clr <= 1'b0;
		@(posedge mclk_i);
		@(negedge mclk_i);
	endtask

	// watcher: the edge that takes a result is followed by its note
	always @(posedge mclk_i) v_d <= cur.valid;
	always @(negedge mclk_i) begin
		if (v_d === 1'b1) begin
			nt = nq.pop_front();
			chk("acc", nt.acc, acc);
			chk("thv", nt.thv, thv);
			chk("rcv", nt.rcv, rcv);
			chk("irq", nt.irq, irq);
		end else if (resetn_i === 1'b1) begin
			// no result was taken, so no interrupt may stand
			chk("irq_idle", 1'b0, irq);
		end
	end

	// hang guard, well beyond the roughly 5300 cycles of the tests
	initial begin
		repeat (20000) @(posedge mclk_i);
		failures++;
		end_sim;
	end

	initial begin
		{resetn_i, cfg_wr, mode6, mode_wr, send, raw, cmp_clr, ovr_clr} = '0;
		{cfg_wd, tcl, cfg_m, thv_m, th, rcl, sdata, rcv_m, acc_m} = '0;
		vt = '0;
		v_d = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (5) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(negedge mclk_i);
		chk("cfg_rst", cap_pkg::CFG_RESET, cfg_rd);
		chk("acc_rst", cap_pkg::ACC_RESET, acc);
		tdone("reset");
		// ground switch with both settings of mode bit 6
		for (i = 0; i < 2; i++) begin
			@(posedge mclk_i);
			mode6 <= i[0];
			wcfg(8'h80);
			@(negedge mclk_i);
			chk("rd", 8'h80, cfg_rd);
			chk("conn", 1'b1, conn);
			chk("resis", i[0], resis);
			wcfg(8'h00);
			@(negedge mclk_i);
			chk("disc", 2'b00, {conn, resis});
		end
		tdone("ground");
		// clamping mode, then off for two results, then signed mode
		wcfg(8'h20);
		res(16'd100);
		res(16'hffe2);
		res(16'hff38);
		res(16'h0005);
		rest(3);
		wcfg(8'h00);
		res(16'h0007);
		res(16'h0007);
		rest(3);
		wcfg(8'h40);
		res(16'h000a);
		res(16'hffe2);
		for (i = 0; i < 20; i++) res(16'($random(seed)));
		rest(3);
		wcfg(8'h60);
		res(16'h0032);
		rest(3);
		tdone("accumulator");
		// result counter masks interrupts, converter write clears it
		rcl <= 16'h0003;
		wcfg(8'h01);
		repeat (7) res(16'h0001);
		rest(3);
		mode_wr <= 1'b1;
		@(posedge mclk_i);
		mode_wr <= 1'b0;
		@(posedge mclk_i);
		@(negedge mclk_i);
		rcv_m = 16'h0;
		chk("rcv_clr", 16'h0, rcv);
		tdone("result count");
		// comparator off, immediate, clearing count, decrementing count
		rcl <= 16'hffff;
		th <= 16'h0064;
		tcl <= 8'h03;
		wcfg(8'h01);
		res(16'h00c8);
		rest(3);
		wcfg(8'h09);
		res(16'h0064);
		res(16'h0063);
		res(16'hff9c);
		res(16'hff9d);
		rest(3);
		// start counting with the flag clear so the limit really sets it
		pulse_clr(0);
		chk("cmp_pre", 1'b0, cmp_f);
		wcfg(8'h11);
		res(16'h0064);
		res(16'h0064);
		res(16'h0000);
		for (i = 0; i < 4; i++) res(16'h0064);
		rest(3);
		chk("cmp_flag", 1'b1, cmp_f);
		wcfg(8'h19);
		// two misses step the count past the limit, else the flag
		// would be set again in the very cycle it is cleared
		res(16'h0000);
		res(16'h0000);
		rest(3);
		pulse_clr(0);
		chk("cmp_clr", 1'b0, cmp_f);
		for (i = 0; i < 3; i++) res(16'h0000);
		for (i = 0; i < 3; i++) res(16'h0064);
		rest(3);
		chk("cmp_again", 1'b1, cmp_f);
		tdone("comparator");
		// voltage results overwrite, only the latest is held
		vt <= '{1'b1, 16'h1234};
		@(posedge mclk_i);
		vt <= '{1'b1, 16'hbeef};
		@(posedge mclk_i);
		vt.valid <= 1'b0;
		@(posedge mclk_i);
		@(negedge mclk_i);
		chk("vt", 16'hbeef, vt_l);
		tdone("vt");
		// overrange: ignored while disabled, then needs 2500 cycles
		@(posedge mclk_i);
		raw <= 1'b1;
		repeat (2600) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("ovr_off", 1'b0, ovr_f);
		wcfg(8'h04);
		// enable is seen one edge before the write task returns; the
		// flag needs the full count, the pulse stage and the status
		repeat (cap_pkg::OVR_CYCLES) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("ovr_early", 1'b0, ovr_f);
		@(negedge mclk_i);
		chk("ovr_set", 1'b1, ovr_f);
		@(posedge mclk_i);
		raw <= 1'b0;
		repeat (5) @(posedge mclk_i);
		pulse_clr(1);
		chk("ovr_clr", 1'b0, ovr_f);
		tdone("overrange");
		end_sim;
	end
endmodule
